//--- dv/tb_vlc_link_control_registers.sv
`timescale 1ns/1ps
`include "vlc_map.svh"
module tb_vlc_link_control_registers
  import vlc_pkg::*;
;
  localparam logic [3:0] a_one = `VLC_OFS_CONTROL_ONE;
  localparam logic [3:0] a_two = `VLC_OFS_CONTROL_TWO;
  localparam logic [3:0] a_stat = `VLC_OFS_LINK_STATUS;
  logic mclk, reset, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic sof_detected, break_detected, eof_idle_seen, ifs_idle_seen, cpu_wait_mode;
  logic irq_source_pending, ifr_ends_with_crc, internal_transmit_out, bus_receive_pin;
  logic [7:0] state_vector_code, state_vector_load_value, sv_seen;
  logic link_clock_tick, symbol_timebase_select, fast_receive_enable, receiver_enable;
  logic status_hold, link_irq, state_machine_reset, analog_loopback, transceiver_drive;
  logic transceiver_tx, internal_receive_in, wakeup_edge, receive_allowed, transmit_allowed;
  logic normalization_bit, state_vector_load, xcvr_loop, remote_active;
  int err_total, n_checks, tick_n, smr_n, wake_n, svl_n;

  vlc_link_control_registers dut (
    .mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sof_detected(sof_detected),
    .break_detected(break_detected), .eof_idle_seen(eof_idle_seen),
    .ifs_idle_seen(ifs_idle_seen), .cpu_wait_mode(cpu_wait_mode),
    .irq_source_pending(irq_source_pending), .state_vector_code(state_vector_code),
    .ifr_ends_with_crc(ifr_ends_with_crc), .internal_transmit_out(internal_transmit_out),
    .bus_receive_pin(bus_receive_pin), .link_clock_tick(link_clock_tick),
    .symbol_timebase_select(symbol_timebase_select),
    .fast_receive_enable(fast_receive_enable), .receiver_enable(receiver_enable),
    .status_hold(status_hold), .link_irq(link_irq),
    .state_machine_reset(state_machine_reset), .analog_loopback(analog_loopback),
    .transceiver_drive(transceiver_drive), .transceiver_tx(transceiver_tx),
    .internal_receive_in(internal_receive_in), .wakeup_edge(wakeup_edge),
    .receive_allowed(receive_allowed), .transmit_allowed(transmit_allowed),
    .normalization_bit(normalization_bit), .state_vector_load(state_vector_load),
    .state_vector_load_value(state_vector_load_value)
  );

  vlc_bus_transceiver_model xcvr (
    .transceiver_drive(transceiver_drive), .transceiver_tx(transceiver_tx),
    .xcvr_loop(xcvr_loop), .remote_active(remote_active),
    .bus_receive_pin(bus_receive_pin)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Pulses are counted, so checks never hinge on exact pulse timing
  always @(posedge mclk) begin
    if (link_clock_tick === 1'b1) tick_n <= tick_n + 1;
    if (state_machine_reset === 1'b1) smr_n <= smr_n + 1;
    if (wakeup_edge === 1'b1) wake_n <= wake_n + 1;
    if (state_vector_load === 1'b1) begin
      svl_n <= svl_n + 1;
      sv_seen <= state_vector_load_value;
    end
  end

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Holds the request until waitrequest is sampled low, giving up as a failure after 40 cycles
  task automatic av(input logic wr_en, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr_en;
    avs_read <= !wr_en;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 40) begin
      err_total++;
      complete_run;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    av(1'b1, a, {24'h0, d});
  endtask

  task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
    av(1'b0, a, 32'h0);
    chk_val(nm, {24'h0, e}, rd);
  endtask

  task automatic pulse(input int k);
    case (k)
      0: sof_detected <= 1'b1;
      1: break_detected <= 1'b1;
      2: eof_idle_seen <= 1'b1;
      default: ifs_idle_seen <= 1'b1;
    endcase
    @(posedge mclk);
    {sof_detected, break_detected, eof_idle_seen, ifs_idle_seen} <= 4'h0;
    cyc(3);
  endtask

  task automatic do_reset;
    reset <= 1'b1;
    cyc(3);
    reset <= 1'b0;
    cyc(1);
  endtask

  initial begin
    #500000;
    err_total++;
    complete_run;
  end

  initial begin
    int n;
    reset = 1'b1;
    {avs_read, avs_write, sof_detected, break_detected, eof_idle_seen} = 5'h00;
    {ifs_idle_seen, cpu_wait_mode, irq_source_pending, ifr_ends_with_crc} = 4'h0;
    {internal_transmit_out, xcvr_loop, remote_active} = 3'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    state_vector_code = 8'h00;
    do_reset;
    rdc("ctrl_one_rst", a_one, 8'h00);
    rdc("ctrl_two_rst", a_two, 8'h00);
    rdc("unmapped", 4'hC, 8'h00);
    chk_bit("irq_rst", 1'b0, link_irq);
    for (int c = 0; c < 4; c++) begin
      do_reset;
      wr(a_one, 8'(c << 4));
      wr(a_one, 8'((3 - c) << 4));
      rdc("rate_field", a_one, 8'(c << 4));
      av(1'b0, a_stat, 32'h0);
      chk_bit("rate_locked", 1'b1, rd[`VLC_ST_RATE_LOCKED]);
      n = tick_n;
      cyc(64);
      chk_val("tick_count", 64 >> c, tick_n - n);
    end
    wr(a_one, 8'h70);
    cyc(2);
    chk_bit("timebase_bin", 1'b1, symbol_timebase_select);
    wr(a_one, 8'h30);
    cyc(2);
    chk_bit("timebase_int", 1'b0, symbol_timebase_select);
    wr(a_one, 8'h31);
    cpu_wait_mode <= 1'b1;
    cyc(4);
    n = tick_n;
    cyc(32);
    chk_val("tick_stopped", 0, tick_n - n);
    wr(a_one, 8'h30);
    cyc(4);
    n = tick_n;
    cyc(32);
    chk_val("tick_in_wait", 4, tick_n - n);
    cpu_wait_mode <= 1'b0;
    state_vector_code <= 8'h10;
    irq_source_pending <= 1'b1;
    cyc(3);
    chk_bit("irq_off", 1'b0, link_irq);
    wr(a_one, 8'h32);
    cyc(10);
    chk_bit("irq_held", 1'b1, link_irq);
    wr(a_one, 8'hB2);
    cyc(2);
    chk_bit("irq_ignoring", 1'b0, link_irq);
    chk_bit("rx_disabled", 1'b0, receiver_enable);
    chk_bit("status_hold", 1'b1, status_hold);
    state_vector_code <= 8'h20;
    cyc(3);
    chk_bit("irq_code20", 1'b1, link_irq);
    state_vector_code <= 8'h10;
    pulse(0);
    rdc("ignore_sof", a_one, 8'h32);
    chk_bit("irq_resumed", 1'b1, link_irq);
    chk_bit("rx_enabled", 1'b1, receiver_enable);
    irq_source_pending <= 1'b0;
    cyc(3);
    chk_bit("irq_cleared", 1'b0, link_irq);
    irq_source_pending <= 1'b1;
    wr(a_one, 8'h30);
    cyc(3);
    chk_bit("irq_gated", 1'b0, link_irq);
    irq_source_pending <= 1'b0;
    wr(a_one, 8'hB0);
    wr(a_two, 8'h20);
    cyc(2);
    chk_bit("fast_rx", 1'b1, fast_receive_enable);
    chk_bit("fast_no_tx", 1'b0, transmit_allowed);
    n = svl_n;
    pulse(1);
    chk_val("sv_load", 1, svl_n - n);
    chk_val("sv_value", 32'h1C, {24'h0, sv_seen});
    chk_bit("fast_cleared", 1'b0, fast_receive_enable);
    rdc("ctrl_two_brk", a_two, 8'h00);
    rdc("ignore_brk", a_one, 8'h30);
    xcvr_loop <= 1'b1;
    n = smr_n;
    wr(a_two, 8'h80);
    internal_transmit_out <= 1'b1;
    cyc(3);
    chk_val("engine_reset", 1, smr_n - n);
    chk_bit("analog_loopback_undriven", 1'b0, transceiver_drive);
    chk_bit("analog_loopback_level", 1'b1, analog_loopback);
    chk_bit("analog_loopback_rx", 1'b1, internal_receive_in);
    internal_transmit_out <= 1'b0;
    xcvr_loop <= 1'b0;
    wr(a_two, 8'h00);
    cyc(2);
    chk_bit("aexit_rx", 1'b0, receive_allowed);
    chk_bit("aexit_tx", 1'b0, transmit_allowed);
    pulse(2);
    chk_bit("aeof_rx", 1'b1, receive_allowed);
    chk_bit("aeof_tx", 1'b0, transmit_allowed);
    pulse(3);
    chk_bit("aifs_tx", 1'b1, transmit_allowed);
    chk_bit("drive_back", 1'b1, transceiver_drive);
    wr(a_two, 8'h40);
    internal_transmit_out <= 1'b1;
    cyc(3);
    chk_bit("digital_loopback_undriven", 1'b0, transceiver_drive);
    chk_bit("digital_loopback_rx", 1'b1, internal_receive_in);
    chk_bit("digital_loopback_tx_off", 1'b0, transceiver_tx);
    n = wake_n;
    remote_active <= 1'b1;
    cyc(8);
    remote_active <= 1'b0;
    cyc(8);
    chk_val("wake_in_loop", 0, wake_n - n);
    internal_transmit_out <= 1'b0;
    wr(a_two, 8'h00);
    cyc(2);
    chk_bit("dexit_rx", 1'b0, receive_allowed);
    chk_bit("dexit_tx", 1'b0, transmit_allowed);
    pulse(2);
    pulse(3);
    chk_bit("deof_rx", 1'b1, receive_allowed);
    chk_bit("difs_tx", 1'b1, transmit_allowed);
    n = wake_n;
    remote_active <= 1'b1;
    cyc(8);
    remote_active <= 1'b0;
    cyc(8);
    chk_val("wake_on_bus", 2, wake_n - n);
    for (int f = 0; f < 2; f++) begin
      for (int c = 0; c < 2; c++) begin
        wr(a_two, 8'(f << 4));
        ifr_ends_with_crc <= 1'(c);
        cyc(3);
        chk_bit("norm_bit", 1'(c ^ f), normalization_bit);
      end
    end
    wr(4'hC, 8'hFF);
    wr(a_stat, 8'hFF);
    rdc("ctrl_two_kept", a_two, 8'h10);
    rdc("ctrl_one_kept", a_one, 8'h30);
    internal_transmit_out <= 1'b1;
    cyc(3);
    chk_bit("tx_pass", 1'b1, transceiver_tx);
    complete_run;
  end
endmodule

//--- dv/vlc_bus_transceiver_model.sv
`timescale 1ns/1ps
module vlc_bus_transceiver_model (
  input wire logic transceiver_drive,
  input wire logic transceiver_tx,
  input wire logic xcvr_loop,
  input wire logic remote_active,
  output logic bus_receive_pin
);
  // Passive bus sits low on the pull-down; other nodes wire-OR onto it
  always_comb begin
    if (xcvr_loop) begin
      bus_receive_pin = transceiver_tx;
    end else begin
      bus_receive_pin = (transceiver_drive & transceiver_tx) | remote_active;
    end
  end
endmodule

//--- hw/vlc_link_control_registers.sv
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "vlc_map.svh"
module vlc_link_control_registers
  import vlc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [`VLC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [`VLC_DATA_W-1:0] avs_writedata,
  output logic [`VLC_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sof_detected,
  input wire logic break_detected,
  input wire logic eof_idle_seen,
  input wire logic ifs_idle_seen,
  input wire logic cpu_wait_mode,
  input wire logic irq_source_pending,
  input wire logic [7:0] state_vector_code,
  input wire logic ifr_ends_with_crc,
  input wire logic internal_transmit_out,
  input wire logic bus_receive_pin,
  output logic link_clock_tick,
  output logic symbol_timebase_select,
  output logic fast_receive_enable,
  output logic receiver_enable,
  output logic status_hold,
  output logic link_irq,
  output logic state_machine_reset,
  output logic analog_loopback,
  output logic transceiver_drive,
  output logic transceiver_tx,
  output logic internal_receive_in,
  output logic wakeup_edge,
  output logic receive_allowed,
  output logic transmit_allowed,
  output logic normalization_bit,
  output logic state_vector_load,
  output logic [7:0] state_vector_load_value
);

  // Rate code to terminal count of the divider
  function automatic logic [`VLC_DIV_CNT_W-1:0] rate_last(input vlc_rate_t code);
    case (code)
      2'b00: rate_last = 3'h0;
      2'b01: rate_last = 3'h1;
      2'b10: rate_last = 3'h3;
      default: rate_last = 3'h7;
    endcase
  endfunction

  function automatic logic addr_is(input logic [`VLC_ADDR_W-1:0] a,
                                   input logic [`VLC_ADDR_W-1:0] ofs);
    addr_is = (a == ofs);
  endfunction

  // Control state
  logic ignore_reg, ignore_next;
  logic timebase_reg, timebase_next;
  vlc_rate_t rate_reg, rate_next;
  logic rate_locked_reg, rate_locked_next;
  logic irq_en_reg, irq_en_next;
  logic wait_stop_reg, wait_stop_next;
  logic analog_loopback_reg, analog_loopback_next;
  logic digital_loopback_reg, digital_loopback_next;
  logic fast_rx_reg, fast_rx_next;
  logic nb_format_reg, nb_format_next;
  vlc_mode_e mode_reg, mode_next;
  logic rx_hold_reg, rx_hold_next;
  logic tx_hold_reg, tx_hold_next;
  logic [`VLC_DIV_CNT_W-1:0] div_reg, div_next;

  // Bus slave state
  logic ack_reg, ack_next;
  logic [`VLC_DATA_W-1:0] rdata_reg, rdata_next;

  // Receive pin synchroniser and filter
  logic rx_s1_reg, rx_s2_reg, rx_s3_reg;
  logic rx_level_reg, rx_level_next;

  // Registered outputs
  logic tick_reg, tick_next;
  logic irq_reg, irq_next;
  logic smr_reg, smr_next;
  logic drive_reg, drive_next;
  logic txo_reg, txo_next;
  logic rxi_reg, rxi_next;
  logic wake_reg, wake_next;
  logic nb_reg, nb_next;
  logic svl_reg, svl_next;
  logic [7:0] svv_reg, svv_next;

  logic wr_c1, wr_c2, rd_go;
  logic clock_run;
  logic irq_allowed;
  logic [7:0] c1_view, c2_view, st_view;

  always_comb begin
    wr_c1 = avs_write && ack_reg && addr_is(avs_address, `VLC_OFS_CONTROL_ONE);
    wr_c2 = avs_write && ack_reg && addr_is(avs_address, `VLC_OFS_CONTROL_TWO);
    rd_go = avs_read && !ack_reg;
    clock_run = !(cpu_wait_mode && wait_stop_reg);
    // Only vector 20h passes while the message is ignored
    irq_allowed = !ignore_reg || (state_vector_code == `VLC_SV_UNMASKED);
    c1_view = `VLC_RESET_BYTE;
    c1_view[`VLC_C1_IGNORE] = ignore_reg;
    c1_view[`VLC_C1_TIMEBASE] = timebase_reg;
    c1_view[`VLC_C1_RATE_HI] = rate_reg[1];
    c1_view[`VLC_C1_RATE_LO] = rate_reg[0];
    c1_view[`VLC_C1_IRQ_EN] = irq_en_reg;
    c1_view[`VLC_C1_WAIT_STOP] = wait_stop_reg;
    c2_view = `VLC_RESET_BYTE;
    c2_view[`VLC_C2_ANALOG_LOOP] = analog_loopback_reg;
    c2_view[`VLC_C2_DIGITAL_LOOP] = digital_loopback_reg;
    c2_view[`VLC_C2_FAST_RX] = fast_rx_reg;
    c2_view[`VLC_C2_NB_FORMAT] = nb_format_reg;
    st_view = `VLC_RESET_BYTE;
    st_view[`VLC_ST_RATE_LOCKED] = rate_locked_reg;
    st_view[`VLC_ST_RX_HOLD] = rx_hold_reg;
    st_view[`VLC_ST_TX_HOLD] = tx_hold_reg;
    st_view[`VLC_ST_RX_LEVEL] = rx_level_reg;
    st_view[`VLC_ST_CLOCK_RUN] = clock_run;
    st_view[`VLC_ST_IGNORING] = ignore_reg;
  end

  // Register file and bus answer
  always_comb begin
    ack_next = (avs_read || avs_write) && !ack_reg;
    rdata_next = rdata_reg;
    if (rd_go) begin
      if (addr_is(avs_address, `VLC_OFS_CONTROL_ONE)) begin
        rdata_next = {24'h000000, c1_view};
      end else if (addr_is(avs_address, `VLC_OFS_CONTROL_TWO)) begin
        rdata_next = {24'h000000, c2_view};
      end else if (addr_is(avs_address, `VLC_OFS_LINK_STATUS)) begin
        rdata_next = {24'h000000, st_view};
      end else begin
        rdata_next = 32'h00000000;
      end
    end
    ignore_next = ignore_reg && !(sof_detected || break_detected);
    timebase_next = timebase_reg;
    rate_next = rate_reg;
    rate_locked_next = rate_locked_reg;
    irq_en_next = irq_en_reg;
    wait_stop_next = wait_stop_reg;
    analog_loopback_next = analog_loopback_reg;
    digital_loopback_next = digital_loopback_reg;
    fast_rx_next = fast_rx_reg;
    nb_format_next = nb_format_reg;
    if (break_detected) begin
      fast_rx_next = 1'b0;
    end
    if (wr_c1) begin
      // A software write in the same cycle wins over the hardware clear
      ignore_next = avs_writedata[`VLC_C1_IGNORE];
      timebase_next = avs_writedata[`VLC_C1_TIMEBASE];
      irq_en_next = avs_writedata[`VLC_C1_IRQ_EN];
      wait_stop_next = avs_writedata[`VLC_C1_WAIT_STOP];
      if (!rate_locked_reg) begin
        rate_next = {avs_writedata[`VLC_C1_RATE_HI], avs_writedata[`VLC_C1_RATE_LO]};
        rate_locked_next = 1'b1;
      end
    end
    if (wr_c2) begin
      analog_loopback_next = avs_writedata[`VLC_C2_ANALOG_LOOP];
      digital_loopback_next = avs_writedata[`VLC_C2_DIGITAL_LOOP];
      fast_rx_next = avs_writedata[`VLC_C2_FAST_RX];
      nb_format_next = avs_writedata[`VLC_C2_NB_FORMAT];
    end
  end

  // Loopback mode sequencing and idle holds
  always_comb begin
    mode_next = mode_reg;
    rx_hold_next = rx_hold_reg && !eof_idle_seen;
    tx_hold_next = tx_hold_reg && !ifs_idle_seen;
    case (mode_reg)
      VLC_MODE_NORMAL: begin
        if (analog_loopback_reg || digital_loopback_reg) begin
          mode_next = VLC_MODE_LOOP;
        end
      end
      VLC_MODE_LOOP: begin
        if (!analog_loopback_reg && !digital_loopback_reg) begin
          mode_next = VLC_MODE_RECOVER;
          rx_hold_next = 1'b1;
          tx_hold_next = 1'b1;
        end
      end
      VLC_MODE_RECOVER: begin
        if (analog_loopback_reg || digital_loopback_reg) begin
          mode_next = VLC_MODE_LOOP;
        end else if (!rx_hold_next && !tx_hold_next) begin
          mode_next = VLC_MODE_NORMAL;
        end
      end
      default: begin
        mode_next = VLC_MODE_NORMAL;
      end
    endcase
  end

  // Divider and registered outputs
  always_comb begin
    div_next = div_reg;
    tick_next = 1'b0;
    if (clock_run) begin
      if (div_reg >= rate_last(rate_reg)) begin
        div_next = '0;
        tick_next = 1'b1;
      end else begin
        div_next = div_reg + 3'h1;
      end
    end
    rx_level_next = rx_level_reg;
    if (rx_s2_reg == rx_s3_reg) begin
      rx_level_next = rx_s3_reg;
    end
    // Bus edges are invisible in digital loopback
    wake_next = (rx_level_next != rx_level_reg) && !digital_loopback_reg;
    if (digital_loopback_reg || analog_loopback_reg) begin
      rxi_next = internal_transmit_out;
    end else begin
      rxi_next = rx_level_reg;
    end
    drive_next = !(analog_loopback_reg || digital_loopback_reg);
    txo_next = internal_transmit_out && !(analog_loopback_reg || digital_loopback_reg);
    // Vector interrupts are not cleared here; the engine owns them
    irq_next = irq_en_reg && irq_source_pending && irq_allowed;
    smr_next = wr_c2 && avs_writedata[`VLC_C2_ANALOG_LOOP] && !analog_loopback_reg;
    nb_next = ifr_ends_with_crc ^ nb_format_reg;
    svl_next = break_detected;
    svv_next = break_detected ? `VLC_SV_BREAK : `VLC_SV_RESET;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      ignore_reg <= 1'b0;
      timebase_reg <= 1'b0;
      rate_reg <= 2'h0;
      rate_locked_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      wait_stop_reg <= 1'b0;
      analog_loopback_reg <= 1'b0;
      digital_loopback_reg <= 1'b0;
      fast_rx_reg <= 1'b0;
      nb_format_reg <= 1'b0;
      mode_reg <= VLC_MODE_NORMAL;
      rx_hold_reg <= 1'b0;
      tx_hold_reg <= 1'b0;
      div_reg <= 3'h0;
      rx_s1_reg <= 1'b0;
      rx_s2_reg <= 1'b0;
      rx_s3_reg <= 1'b0;
      rx_level_reg <= 1'b0;
      tick_reg <= 1'b0;
      irq_reg <= 1'b0;
      smr_reg <= 1'b0;
      drive_reg <= 1'b0;
      txo_reg <= 1'b0;
      rxi_reg <= 1'b0;
      wake_reg <= 1'b0;
      nb_reg <= 1'b0;
      svl_reg <= 1'b0;
      svv_reg <= `VLC_SV_RESET;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      ignore_reg <= ignore_next;
      timebase_reg <= timebase_next;
      rate_reg <= rate_next;
      rate_locked_reg <= rate_locked_next;
      irq_en_reg <= irq_en_next;
      wait_stop_reg <= wait_stop_next;
      analog_loopback_reg <= analog_loopback_next;
      digital_loopback_reg <= digital_loopback_next;
      fast_rx_reg <= fast_rx_next;
      nb_format_reg <= nb_format_next;
      mode_reg <= mode_next;
      rx_hold_reg <= rx_hold_next;
      tx_hold_reg <= tx_hold_next;
      div_reg <= div_next;
      rx_s1_reg <= bus_receive_pin;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      rx_level_reg <= rx_level_next;
      tick_reg <= tick_next;
      irq_reg <= irq_next;
      smr_reg <= smr_next;
      drive_reg <= drive_next;
      txo_reg <= txo_next;
      rxi_reg <= rxi_next;
      wake_reg <= wake_next;
      nb_reg <= nb_next;
      svl_reg <= svl_next;
      svv_reg <= svv_next;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign avs_readdata = rdata_reg;
  assign link_clock_tick = tick_reg;
  assign symbol_timebase_select = timebase_reg;
  assign fast_receive_enable = fast_rx_reg;
  assign receiver_enable = !ignore_reg;
  assign status_hold = ignore_reg;
  assign link_irq = irq_reg;
  assign state_machine_reset = smr_reg;
  assign analog_loopback = analog_loopback_reg;
  assign transceiver_drive = drive_reg;
  assign transceiver_tx = txo_reg;
  assign internal_receive_in = rxi_reg;
  assign wakeup_edge = wake_reg;
  assign receive_allowed = !rx_hold_reg && !ignore_reg;
  assign transmit_allowed = !tx_hold_reg && !fast_rx_reg;
  assign normalization_bit = nb_reg;
  assign state_vector_load = svl_reg;
  assign state_vector_load_value = svv_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  ignore_clear_a: assert property ((sof_detected || break_detected) && !wr_c1
    |=> !ignore_reg)
    else $error("ignore flag not cleared by frame start");
  irq_mask_a: assert property (ignore_reg && state_vector_code != `VLC_SV_UNMASKED
    |=> !link_irq)
    else $error("interrupt leaked while ignoring");
  rate_lock_a: assert property (rate_locked_reg |=> $stable(rate_reg))
    else $error("rate field changed after lock");
  rate_once_a: assert property (wr_c1 && !rate_locked_reg |=> rate_locked_reg)
    else $error("first rate write did not lock");
  div_period_a: assert property (tick_reg && rate_reg == 2'b11 && clock_run
    ##1 (clock_run && rate_reg == 2'b11) [*7] |=> tick_reg)
    else $error("divide by eight period wrong");
  wait_stop_a: assert property (!clock_run |=> !tick_reg)
    else $error("tick while clocks stopped");
  irq_gate_a: assert property (!irq_en_reg |=> !link_irq)
    else $error("interrupt with enable clear");
  loop_undriven_a: assert property (analog_loopback_reg || digital_loopback_reg |=> !transceiver_drive)
    else $error("bus driven in loopback");
  loop_wake_a: assert property (digital_loopback_reg |=> !wakeup_edge)
    else $error("wakeup from bus in loopback");
  loop_path_a: assert property (digital_loopback_reg
    |=> internal_receive_in == $past(internal_transmit_out))
    else $error("loopback path broken");
  recover_hold_a: assert property (mode_reg == VLC_MODE_LOOP && !analog_loopback_reg && !digital_loopback_reg
    |=> !transmit_allowed && !receive_allowed)
    else $error("no idle wait after loopback");
  break_load_a: assert property (break_detected
    |=> state_vector_load && state_vector_load_value == `VLC_SV_BREAK && !fast_rx_reg
    ##1 !state_vector_load)
    else $error("break did not load vector");
  nb_format_a: assert property (normalization_bit
    == ($past(ifr_ends_with_crc) ^ $past(nb_format_reg)))
    else $error("normalization bit wrong");
  bus_answer_a: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  cover_lock_c: cover property (wr_c1 && rate_locked_reg);
  cover_break_c: cover property (ignore_reg && break_detected);
  cover_recover_c: cover property (mode_reg == VLC_MODE_RECOVER ##1 mode_reg == VLC_MODE_NORMAL);

endmodule

//--- hw/vlc_map.svh
// Summary of operation
// - Ignore-message set disables receiver until next start-of-frame, dropping current message.
// - Start-of-frame or break clears ignore-message; interrupts and status resume.
// - While ignoring, mask all interrupts except vector 20h; hold status at reset.
// - Timebase select picks 1.048576 MHz symbol timing when 1, 1 MHz when 0.
// - Rate field divides crystal clock: 00 by 1, 01 by 2, 10 by 4, 11 by 8.
// - Rate field accepts one write after reset, then reads only.
// - Interrupt enable gates controller interrupt requests in run mode.
// - Request held until all sources cleared; reset gives state vector 00h.
// - Enable bit never clears pending vector interrupts; clearing it may lose them.
// - Wait-clock bit: 0 keeps clocks in CPU wait, 1 stops them.
// - Analog loopback resets protocol engine, loops drive stage, bus undriven (code loops transmit to receive internally, transceiver_tx held low).
// - After analog loopback clears, need end-of-frame idle to receive, separator to send.
// - Digital loopback ties transmit to receive, leaves bus, no wakeup from bus edges.
// - After digital loopback clears, need end-of-frame idle to receive, separator to send.
// - Fast receive bit: receive-only 41.6 Kbps when set, 10.4 Kbps both ways when clear.
// - Break clears fast receive bit and loads state vector with 1Ch.
// - Normalization bit is 1 for CRC-ending responses when format 0; inverted when 1.
`ifndef VLC_MAP_SVH
`define VLC_MAP_SVH
`define VLC_ADDR_W 4
`define VLC_DATA_W 32
`define VLC_OFS_CONTROL_ONE 4'h0
`define VLC_OFS_CONTROL_TWO 4'h4
`define VLC_OFS_LINK_STATUS 4'h8
`define VLC_C1_IGNORE 7
`define VLC_C1_TIMEBASE 6
`define VLC_C1_RATE_HI 5
`define VLC_C1_RATE_LO 4
`define VLC_C1_IRQ_EN 1
`define VLC_C1_WAIT_STOP 0
`define VLC_C2_ANALOG_LOOP 7
`define VLC_C2_DIGITAL_LOOP 6
`define VLC_C2_FAST_RX 5
`define VLC_C2_NB_FORMAT 4
`define VLC_ST_RATE_LOCKED 0
`define VLC_ST_RX_HOLD 1
`define VLC_ST_TX_HOLD 2
`define VLC_ST_RX_LEVEL 3
`define VLC_ST_CLOCK_RUN 4
`define VLC_ST_IGNORING 5
`define VLC_RESET_BYTE 8'h00
`define VLC_SV_RESET 8'h00
`define VLC_SV_UNMASKED 8'h20
`define VLC_SV_BREAK 8'h1C
`define VLC_DIV_CNT_W 3
`define VLC_FREQ_BINARY_HZ 1048576
`define VLC_FREQ_INTEGER_HZ 1000000
`define VLC_RATE_NORMAL_BPS 10400
`define VLC_RATE_FAST_BPS 41600
`endif

//--- hw/vlc_pkg.sv
package vlc_pkg;
  typedef logic [7:0] vlc_byte_t;
  typedef logic [1:0] vlc_rate_t;
  typedef enum logic [1:0] {
    VLC_MODE_NORMAL,
    VLC_MODE_LOOP,
    VLC_MODE_RECOVER
  } vlc_mode_e;
endpackage
